/* fir_pkg.sv */
// Purpose: Shared types and constants for the flash identifier readout host
// Assumes: 200 MHz core clock, parallel NOR flash with 64 uniform sectors
// Notes:   Wait times are host-side margins, not device limits
package fir_pkg;

  // Clock and wait times (ns), cycle counts round up
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETUP_NS      = 20;
  localparam int ACCESS_NS     = 100;
  localparam int WE_PULSE_NS   = 50;
  localparam int RECOVER_NS    = 20;
  localparam int TMR_W         = 8;
  localparam logic [TMR_W-1:0] SETUP_CYC =
    TMR_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] ACCESS_CYC =
    TMR_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] WE_PULSE_CYC =
    TMR_W'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] RECOVER_CYC =
    TMR_W'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Address pin positions
  localparam int ADDR_W   = 21;
  localparam int SECT_LSB = 15;
  localparam int SECT_MSB = 20;
  localparam int IGN_HI_MSB = 14;
  localparam int IGN_HI_LSB = 10;
  localparam int A9_BIT   = 9;
  localparam int A8_BIT   = 8;
  localparam int A7_BIT   = 7;
  localparam int A6_BIT   = 6;
  localparam int A5_BIT   = 5;
  localparam int A4_BIT   = 4;
  localparam int A3_BIT   = 3;
  localparam int A2_BIT   = 2;
  localparam int A1_BIT   = 1;
  localparam int A0_BIT   = 0;

  // Indicator byte fields
  localparam int LOCK_BIT    = 7;
  localparam int WP_HIGH_BIT = 4;
  localparam int PROT_BIT    = 0;

  // Read kinds requested by the user
  typedef enum logic [2:0] {
    FIR_K_ARRAY = 3'h0,
    FIR_K_MANUF = 3'h1,
    FIR_K_DEV1  = 3'h2,
    FIR_K_DEV2  = 3'h3,
    FIR_K_DEV3  = 3'h4,
    FIR_K_PROT  = 3'h5,
    FIR_K_IND   = 3'h6
  } fir_kind_e;

  // Select code {A3=A2, A1, A0} per kind
  localparam logic [2:0] CODE_MANUF = 3'h0;
  localparam logic [2:0] CODE_DEV1  = 3'h1;
  localparam logic [2:0] CODE_DEV2  = 3'h6;
  localparam logic [2:0] CODE_DEV3  = 3'h7;
  localparam logic [2:0] CODE_PROT  = 3'h2;
  localparam logic [2:0] CODE_IND   = 3'h3;

  function automatic logic [2:0] fir_code(input fir_kind_e k);
    unique case (k)
      FIR_K_MANUF: fir_code = CODE_MANUF;
      FIR_K_DEV1:  fir_code = CODE_DEV1;
      FIR_K_DEV2:  fir_code = CODE_DEV2;
      FIR_K_DEV3:  fir_code = CODE_DEV3;
      FIR_K_PROT:  fir_code = CODE_PROT;
      FIR_K_IND:   fir_code = CODE_IND;
      default:     fir_code = CODE_MANUF;
    endcase
  endfunction : fir_code

  // User request
  typedef struct packed {
    fir_kind_e         kind;
    logic [5:0]        sector_number;
    logic [ADDR_W:0]   byte_addr;
    logic              use_cmd;
    logic              word_mode;
  } fir_req_s;

  // Result of one read
  typedef struct packed {
    logic [15:0] data;
    logic        is_protected;
    logic        locked;
    logic        wp_high;
  } fir_rsp_s;

  // Flash pin drive
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              amin1;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              byte_n;
    logic              elevated_id_voltage;
    logic [15:0]       dq_out;
    logic              dq_oe_n;
  } fir_pins_s;

  localparam fir_pins_s PINS_IDLE = '{addr: '0, amin1: 1'b0, ce_n: 1'b1,
    oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b1, elevated_id_voltage: 1'b0,
    dq_out: 16'h0000, dq_oe_n: 1'b1};

endpackage : fir_pkg

/* fir_wait_timer.sv */
// Purpose: Down counter giving a one-cycle done pulse after a loaded count
// Assumes: Count of at least one
// Notes:   A new load restarts the count
`timescale 1ns/1ps
`default_nettype none
module fir_wait_timer
  import fir_pkg::*;
(
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_load,
  input  wire logic [TMR_W-1:0] i_count,
  // Status
  output logic                  o_done
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             busy;
  } fir_tmr_s;

  fir_tmr_s tmr_ff;
  fir_tmr_s nxt_tmr;

  // Count down while busy
  always_comb begin
    nxt_tmr = tmr_ff;
    if (i_load) begin
      nxt_tmr.cnt  = i_count;
      nxt_tmr.busy = 1'b1;
    end else if (tmr_ff.busy) begin
      nxt_tmr.cnt  = tmr_ff.cnt - TMR_W'(1);
      nxt_tmr.busy = (tmr_ff.cnt != TMR_W'(1));
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  // Done from state only, so a reload on done forms no loop
  assign o_done = tmr_ff.busy && (tmr_ff.cnt == TMR_W'(1));

endmodule : fir_wait_timer
`default_nettype wire

/* fir_host.sv */
// Purpose: Host that reads identifier codes, protection and indicator bytes
// Assumes: One request at a time, flash pins driven directly
// Notes:   Command method issues one write of a chosen command word
//
// What this block does
// [RULE1] Byte mode uses A-1; word mode A0 lsb
// [RULE2] Identifier codes read on low data byte in byte mode, whole word in word mode
// [RULE3] Hold elevated voltage on A9 whole read
// [RULE4] Command method enters autoselect without high voltage
// [RULE5] CE low, OE low, WE high, A6 low
// [RULE6] Code 000 selects manufacturer identification
// [RULE7] Device code cycles 001, 110, 111
// [RULE8] Sector on A20-A15, code 010, protected flag
// [RULE9] Indicator 98h/18h when top sector guarded
// [RULE10] Indicator 88h/08h bottom guarded; bit7 lock
// [RULE11] Ignored address bits and upper byte
// [RULE12] Levels settle before data is sampled
// [RULE13] Otherwise read normal array contents
`timescale 1ns/1ps
`default_nettype none
module fir_host
  import fir_pkg::*;
#(
  parameter logic [ADDR_W-1:0] P_CMD_ADDR   = 21'h000000,
  parameter logic [15:0]       P_ENTER_DATA = 16'h0001,
  parameter logic [15:0]       P_EXIT_DATA  = 16'h0002
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // User request
  input  wire logic        i_req_valid,
  input  wire fir_req_s    i_req,
  output logic             o_req_ready,
  // User result
  output logic             o_rsp_valid,
  output fir_rsp_s         o_rsp,
  // Flash pins
  output fir_pins_s        o_pins,
  input  wire logic [15:0] i_dq
);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_CMDW  = 7'b0000010,
    ST_CMDR  = 7'b0000100,
    ST_SETUP = 7'b0001000,
    ST_READ  = 7'b0010000,
    ST_CAPT  = 7'b0100000,
    ST_DONE  = 7'b1000000
  } fir_state_e;

  typedef struct packed {
    fir_state_e        state;
    fir_req_s          req;
    fir_rsp_s          rsp;
    fir_pins_s         pins;
    logic [2:0][15:0]  sync;
    logic              rsp_valid;
  } fir_host_s;

  fir_host_s        st_ff;
  fir_host_s        nxt_st;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic             tmr_done;
  logic             lo_only;
  logic [15:0]      byte_mask;

  fir_wait_timer u_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_load     (tmr_load),
    .i_count    (tmr_count),
    .o_done     (tmr_done)
  );

  // Only the low byte carries a code in byte mode and for flag reads
  assign lo_only   = !st_ff.req.word_mode || st_ff.req.kind == FIR_K_PROT ||
                     st_ff.req.kind == FIR_K_IND;  // RULE11
  assign byte_mask = lo_only ? 16'h00FF : 16'hFFFF;

  // Read address for a request
  function automatic logic [ADDR_W-1:0] read_addr(input fir_req_s r);
    logic [ADDR_W-1:0] a;
    logic [2:0]        c;
    a = '0;
    c = fir_code(r.kind);
    if (r.kind == FIR_K_ARRAY) begin
      a = r.byte_addr[ADDR_W:1];                      // RULE1
    end else begin
      // Ignored bits left low, A6 low
      if (r.kind == FIR_K_PROT) begin
        a[SECT_MSB:SECT_LSB] = r.sector_number;       // RULE8
      end
      a[A3_BIT] = c[2];                               // RULE6
      a[A2_BIT] = c[2];                               // RULE7
      a[A1_BIT] = c[1];
      a[A0_BIT] = c[0];
    end
    read_addr = a;
  endfunction : read_addr

  // Next state
  always_comb begin
    nxt_st    = st_ff;
    tmr_load  = 1'b0;
    tmr_count = SETUP_CYC;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.sync = {st_ff.sync[1:0], i_dq};
    unique case (st_ff.state)
      ST_IDLE: begin
        if (i_req_valid) begin
          nxt_st.req         = i_req;
          nxt_st.pins.ce_n   = 1'b0;                  // RULE5
          nxt_st.pins.byte_n = i_req.word_mode;       // RULE1
          tmr_load = 1'b1;
          if (i_req.use_cmd) begin
            // One command write: enter or leave autoselect
            nxt_st.pins.addr    = P_CMD_ADDR;
            nxt_st.pins.dq_out  = (i_req.kind == FIR_K_ARRAY) ?
                                  P_EXIT_DATA : P_ENTER_DATA;  // RULE4
            nxt_st.pins.dq_oe_n = 1'b0;
            nxt_st.pins.we_n    = 1'b0;
            tmr_count    = WE_PULSE_CYC;
            nxt_st.state = ST_CMDW;
          end else begin
            nxt_st.pins.addr  = read_addr(i_req);
            nxt_st.pins.amin1 = i_req.byte_addr[0] & ~i_req.word_mode;  // RULE1
            nxt_st.pins.elevated_id_voltage = (i_req.kind != FIR_K_ARRAY); // RULE3
            nxt_st.state = ST_SETUP;
          end
        end
      end
      ST_CMDW: begin
        if (tmr_done) begin
          nxt_st.pins.we_n = 1'b1;
          tmr_load     = 1'b1;
          tmr_count    = RECOVER_CYC;
          nxt_st.state = ST_CMDR;
        end
      end
      ST_CMDR: begin
        if (tmr_done) begin
          nxt_st.pins.dq_oe_n = 1'b1;
          nxt_st.pins.addr    = read_addr(st_ff.req);
          nxt_st.pins.amin1   = st_ff.req.byte_addr[0] & ~st_ff.req.word_mode;
          tmr_load     = 1'b1;
          nxt_st.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Address and voltage settle before output enable
        if (tmr_done) begin                           // RULE12
          nxt_st.pins.oe_n = 1'b0;                    // RULE5
          tmr_load     = 1'b1;
          tmr_count    = ACCESS_CYC;
          nxt_st.state = ST_READ;
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          nxt_st.state = ST_CAPT;
        end
      end
      ST_CAPT: begin
        // Take data once two synchroniser stages agree
        // Released upper lines float, so only the used lanes must agree
        if ((st_ff.sync[1] & byte_mask) == (st_ff.sync[2] & byte_mask)) begin
          nxt_st.rsp = '0;
          nxt_st.rsp.data = st_ff.sync[2] & byte_mask;  // RULE2 RULE11
          if (st_ff.req.kind == FIR_K_PROT) begin
            nxt_st.rsp.is_protected = st_ff.sync[2][PROT_BIT];  // RULE8
          end
          if (st_ff.req.kind == FIR_K_IND) begin
            nxt_st.rsp.locked  = st_ff.sync[2][LOCK_BIT];       // RULE10
            nxt_st.rsp.wp_high = st_ff.sync[2][WP_HIGH_BIT];    // RULE9
          end
          nxt_st.pins.oe_n = 1'b1;
          nxt_st.state     = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_st.pins      = PINS_IDLE;
        nxt_st.rsp_valid = 1'b1;
        nxt_st.state     = ST_IDLE;
      end
      default: begin
        nxt_st.pins  = PINS_IDLE;
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_ff       <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.pins  <= PINS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_req_ready = (st_ff.state == ST_IDLE);
  assign o_rsp_valid = st_ff.rsp_valid;
  assign o_rsp       = st_ff.rsp;
  assign o_pins      = st_ff.pins;

  // Autoselect read by high voltage in progress
  logic hv_read;
  assign hv_read = !st_ff.pins.oe_n && st_ff.req.kind != FIR_K_ARRAY && !st_ff.req.use_cmd;

  AST_HV_HELD: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE3
    hv_read |-> st_ff.pins.elevated_id_voltage)
    else $error("A9 voltage dropped during read");

  AST_CMD_NO_HV: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE4
    st_ff.req.use_cmd && st_ff.state != ST_IDLE |-> !st_ff.pins.elevated_id_voltage)
    else $error("High voltage used with command method");

  AST_CTRL_LEVELS: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE5
    !st_ff.pins.oe_n |-> !st_ff.pins.ce_n && st_ff.pins.we_n && st_ff.pins.dq_oe_n)
    else $error("Bad control levels during read");

  AST_MANUF_CODE: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
    !st_ff.pins.oe_n && st_ff.req.kind == FIR_K_MANUF
      |-> st_ff.pins.addr[A3_BIT:A0_BIT] == 4'h0 && !st_ff.pins.addr[A6_BIT])
    else $error("Manufacturer code address wrong");

  AST_DEV_CODE: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE7
    !st_ff.pins.oe_n && st_ff.req.kind == FIR_K_DEV2
      |-> st_ff.pins.addr[A3_BIT:A0_BIT] == 4'hE)
    else $error("Device cycle 2 address wrong");

  AST_SECTOR: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE8
    !st_ff.pins.oe_n && st_ff.req.kind == FIR_K_PROT
      |-> st_ff.pins.addr[SECT_MSB:SECT_LSB] == st_ff.req.sector_number
       && st_ff.pins.addr[A3_BIT:A0_BIT] == 4'h2)
    else $error("Protection read address wrong");

  AST_IGNORED_LOW: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE11
    !st_ff.pins.oe_n && st_ff.req.kind != FIR_K_ARRAY
      |-> st_ff.pins.addr[IGN_HI_MSB:IGN_HI_LSB] == 5'h00
       && st_ff.pins.addr[A9_BIT:A7_BIT] == 3'h0 && st_ff.pins.addr[A5_BIT:A4_BIT] == 2'h0)
    else $error("Ignored address bits not low");

  AST_SETTLE: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE12
    $fell(st_ff.pins.oe_n) |-> $stable(st_ff.pins.addr) && $past(st_ff.state == ST_SETUP))
    else $error("Output enable before settling");

  AST_IND_FLAGS: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE10
    st_ff.rsp_valid && st_ff.req.kind == FIR_K_IND
      |-> st_ff.rsp.locked == st_ff.rsp.data[LOCK_BIT]
       && st_ff.rsp.wp_high == st_ff.rsp.data[WP_HIGH_BIT])
    else $error("Indicator flags mismatch");

  AST_ARRAY_ADDR: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE13
    !st_ff.pins.oe_n && st_ff.req.kind == FIR_K_ARRAY
      |-> st_ff.pins.addr == st_ff.req.byte_addr[ADDR_W:1] && !st_ff.pins.elevated_id_voltage)
    else $error("Array read address wrong");

endmodule : fir_host
`default_nettype wire

/* fir_flash_model.sv */
// Purpose: Behavioural flash part for array and identifier reads
// Assumes: Pins come straight from the host; no access delay modelled
// Notes:   Released data lines toggle every cycle; code values are arbitrary
`timescale 1ns/1ps
`default_nettype none
module fir_flash_model
  import fir_pkg::*;
#(
  parameter logic [ADDR_W-1:0] P_CMD_ADDR   = 21'h000000,
  parameter logic [15:0]       P_ENTER_DATA = 16'h0001,
  parameter logic [15:0]       P_EXIT_DATA  = 16'h0002,
  parameter logic [15:0]       P_ID [4]     = '{4{16'h0000}}, // Arbitrary values
  parameter logic [63:0]       P_PROT       = 64'h0000_0000_0000_0000
) (
  // Clock for the released-line pattern
  input  wire logic      i_core_clk,
  // Host pins and straps
  input  wire fir_pins_s i_pins,
  input  wire logic      i_locked,
  input  wire logic      i_wp_high,
  // Data lines
  output logic [15:0]    o_dq
);
  logic              cmd_mode = 1'b0;
  logic              tog_ff   = 1'b0;
  logic              auto_on;
  logic [2:0]        code;
  logic [15:0]       arr;
  logic [15:0]       val;
  logic [15:0]       flt;
  logic [ADDR_W-1:0] a;

  // Command word taken as write enable rises
  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n && !i_pins.dq_oe_n && i_pins.addr == P_CMD_ADDR) begin
      if (i_pins.dq_out == P_ENTER_DATA) cmd_mode <= 1'b1;
      if (i_pins.dq_out == P_EXIT_DATA) cmd_mode <= 1'b0;
    end
  end

  // Pattern so a released bus never looks stable
  always @(posedge i_core_clk) tog_ff <= ~tog_ff;

  // Read decode; ignored address bits never looked at
  always_comb begin
    a       = i_pins.addr;
    flt     = {16{tog_ff}} ^ 16'h3C96;
    auto_on = cmd_mode || (i_pins.elevated_id_voltage && i_pins.we_n && !a[A6_BIT]);
    code    = {a[A3_BIT] & a[A2_BIT], a[A1_BIT], a[A0_BIT]};
    arr     = a[15:0] ^ {a[20:16], 11'h000} ^ 16'h5A3C;
    case (code)
      CODE_MANUF: val = P_ID[0];
      CODE_DEV1:  val = P_ID[1];
      CODE_DEV2:  val = P_ID[2];
      CODE_DEV3:  val = P_ID[3];
      CODE_PROT:  val = {flt[15:8], 7'h00, P_PROT[a[SECT_MSB:SECT_LSB]]};
      CODE_IND:   val = {flt[15:8], i_locked, 2'b00, i_wp_high, 4'h8};
      default:    val = flt;
    endcase
    if (!auto_on) val = arr;
    if (!i_pins.byte_n) val = {flt[15:8], (auto_on || !i_pins.amin1) ? val[7:0] : val[15:8]};
    o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? val : flt;
  end
endmodule : fir_flash_model
`default_nettype wire

/* fir_tb.sv */
// Purpose: Self-checking bench for the identifier readout host
// Assumes: Flash model answers at once; straps set by the bench
// Notes:   Random requests from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
  import fir_pkg::*;
  localparam logic [15:0] M_ID [4]  = '{16'h3A5C, 16'h6E61, 16'h6E47, 16'h6E2B}; // Arbitrary
  localparam logic [63:0] M_PROT    = 64'h8000_0000_0000_0005;
  localparam logic [5:0]  SECTS [6] = '{6'h00, 6'h01, 6'h02, 6'h3D, 6'h3E, 6'h3F};
  localparam logic [21:0] ADRS [3]  = '{22'h3FFFFF, 22'h3F0000, 22'h000001};
  logic        clk;
  logic        rst       = 1'b1;
  logic        req_valid = 1'b0;
  fir_req_s    req       = '0;
  logic        req_ready;
  logic        rsp_valid;
  fir_rsp_s    rsp;
  fir_pins_s   pins;
  logic [15:0] dq_dev;
  logic [15:0] dq;
  logic        lock_s    = 1'b0;
  logic        wph_s     = 1'b0;
  logic        hv_seen   = 1'b0;
  fir_req_s    r;
  int          n_errors  = 0;
  int          compares  = 0;
  int          lvl_bad   = 0;

  // Bus level from both drivers
  assign dq = pins.dq_oe_n ? dq_dev : pins.dq_out;

  fir_host i_dut (.i_core_clk(clk), .i_rst(rst), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_pins(pins), .i_dq(dq));
  fir_flash_model #(.P_ID(M_ID), .P_PROT(M_PROT)) i_flash (.i_core_clk(clk), .i_pins(pins),
    .i_locked(lock_s), .i_wp_high(wph_s), .o_dq(dq_dev));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // High voltage use and levels while it is applied
  always @(posedge clk) begin
    if (pins.elevated_id_voltage === 1'b1) hv_seen <= 1'b1;
    if (pins.elevated_id_voltage === 1'b1 && pins.oe_n === 1'b0 && !(pins.ce_n === 1'b0
        && pins.we_n === 1'b1 && pins.addr[A6_BIT] === 1'b0)) lvl_bad++;
  end

  // Expected read result
  function automatic logic [15:0] exp_data(input fir_req_s q);
    logic [20:0] w;
    logic [15:0] d;
    w = q.byte_addr[21:1];
    d = w[15:0] ^ {w[20:16], 11'h000} ^ 16'h5A3C;
    case (q.kind)
      FIR_K_ARRAY: d = q.word_mode ? d : {8'h00, q.byte_addr[0] ? d[15:8] : d[7:0]};
      FIR_K_PROT:  d = {15'h0000, M_PROT[q.sector_number]};
      FIR_K_IND:   d = {8'h00, lock_s, 2'b00, wph_s, 4'h8};
      default:     d = q.word_mode ? M_ID[q.kind - 1] : {8'h00, M_ID[q.kind - 1][7:0]};
    endcase
    return d;
  endfunction : exp_data

  // Random request of one kind
  function automatic fir_req_s mk(input fir_kind_e k, input logic cmd, input logic wm);
    fir_req_s q;
    q.sector_number = 6'($urandom);
    q.byte_addr     = 22'($urandom);
    q.kind          = k;
    q.use_cmd       = cmd;
    q.word_mode     = wm;
    return q;
  endfunction : mk

  // One request and its checks
  task automatic run(input fir_req_s q);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    hv_seen   = 1'b0;
    req       = q;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    `CHK("req_ready", 1'b0, req_ready)
    req       = {1'b0, $urandom};
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("hv_use", (q.kind != FIR_K_ARRAY) && !q.use_cmd, hv_seen)
    case (q.kind)
      FIR_K_ARRAY: `CHK("array_data", exp_data(q), rsp.data)
      FIR_K_MANUF: `CHK("manuf_code", exp_data(q), rsp.data)
      FIR_K_PROT:  `CHK("prot_byte", exp_data(q), rsp.data)
      FIR_K_IND:   `CHK("ind_byte", exp_data(q), rsp.data)
      default:     `CHK("dev_code", exp_data(q), rsp.data)
    endcase
    if (q.kind == FIR_K_ARRAY && !q.word_mode) `CHK("byte_lane", exp_data(q), rsp.data)
    if (q.kind == FIR_K_PROT) `CHK("prot_flag", M_PROT[q.sector_number], rsp.is_protected)
    if (q.kind == FIR_K_IND) `CHK("lock_flag", lock_s, rsp.locked)
    if (q.kind == FIR_K_IND) `CHK("wph_flag", wph_s, rsp.wp_high)
  endtask : run

  // Counts and verdict
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    #(5 * 60000);
    n_errors++;
    print_verdict();
  end

  // Test sequence
  initial begin
    void'($urandom(32'h3AD7));
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    `CHK("pins_idle", PINS_IDLE, pins)
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      for (int k = 1; k < 7; k++) begin
        for (int j = 0; j < 4; j++) begin
          lock_s = j[0];
          wph_s  = j[1];
          run(mk(fir_kind_e'(k), m[1], m[0]));
        end
      end
      run(mk(FIR_K_ARRAY, m[1], m[0]));
    end
    $display("test codes done");
    for (int s = 0; s < 12; s++) begin
      r = mk(FIR_K_PROT, s[1], s[0]);
      if (s < 6) r.sector_number = SECTS[s];
      run(r);
    end
    run(mk(FIR_K_ARRAY, 1'b1, 1'b0));
    $display("test sectors done");
    for (int s = 0; s < 16; s++) begin
      r = mk(FIR_K_ARRAY, 1'b0, s[0]);
      if (s < 6) r.byte_addr = ADRS[s >> 1];
      run(r);
    end
    $display("test array done");
    req       = mk(FIR_K_MANUF, 1'b1, 1'b1);
    req_valid = 1'b1;
    @(posedge clk);
    #1 req_valid = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    `CHK("pins_abort", PINS_IDLE, pins)
    run(mk(FIR_K_DEV1, 1'b0, 1'b1));
    run(mk(FIR_K_ARRAY, 1'b1, 1'b1));
    $display("test abort done");
    `CHK("level_faults", 0, lvl_bad)
    print_verdict();
  end
endmodule : tb
`default_nettype wire
